// file: include/iedu_pkg.sv
// Types shared by the exception entry unit
package iedu_pkg;
    typedef enum logic [2:0] {
        IEDU_IDLE, IEDU_ADJUST, IEDU_SAVE, IEDU_CLEAR, IEDU_VECTOR, IEDU_DISPATCH
    } iedu_state_e;
    typedef logic [20:0] iedu_addr_t;
    typedef logic [15:0] iedu_word_t;
endpackage : iedu_pkg

// file: include/iedu_regs.svh
// Register offsets, field positions and reset values of the exception entry unit
`ifndef IEDU_REGS_SVH
`define IEDU_REGS_SVH
`define IEDU_OFS_STACK_PTR   12'h000
`define IEDU_OFS_BASE        12'h004
`define IEDU_OFS_PIN_CTRL    12'h008
`define IEDU_OFS_NMI_STAT    12'h00C
`define IEDU_OFS_CONTEXT     12'h010
`define IEDU_OFS_STACKED     12'h014
`define IEDU_FLD_EN          0
`define IEDU_FLD_PIN         1
`define IEDU_FLD_LOCK        2
`define IEDU_FLD_EXT         6
`define IEDU_PSW_T           1
`define IEDU_PSW_P           10
`define IEDU_PSW_I           11
`define IEDU_STACK_STEP      21'h000004
`define IEDU_NMI_VECTOR      5'h01
`define IEDU_MASKABLE_BASE   5'h10
`define IEDU_RST_ZERO        32'h00000000
`endif

// file: logic/iedu_unit.sv
// Interrupt entry, return and pin trap sequencer with APB register access
//
// Function
// [RULE1] Entry lowers stack pointer by four first
// [RULE2] Entry pushes program counter and status word
// [RULE3] Entry clears enable, trace-pending, trace bits
// [RULE4] Vector number read from vector register
// [RULE5] Entry address is base plus twice vector
// [RULE6] Entry word padded zero below and above
// [RULE7] Base is 21 bits, top five, bit0 zero
// [RULE8] Thirty-two entries; pin trap uses vector one
// [RULE9] Software keeps routine addresses below C000
// [RULE10] Return pops context, raises pointer by four
// [RULE11] Stack grows down, shrinks up
// [RULE12] Software sets stack pointer and base first
// [RULE13] Pin falling edge raises trap when enabled
// [RULE14] Pin passes internal two-stage synchroniser
// [RULE15] Reset clears one-shot and lock bits
// [RULE16] Taken trap clears one-shot enable
// [RULE17] Handler re-arms one-shot enable if wanted
// [RULE18] Lock stays until reset, every edge traps
// [RULE19] Lock set makes one-shot bit ignored
// [RULE20] Vector register gives 5-bit highest source
// [RULE21] Entry steps run in fixed order
`timescale 1ns/100ps
`include "iedu_regs.svh"
module iedu_unit
    import iedu_pkg::*;
(
    // Clock and reset
    input  wire logic            REF_CLK,
    input  wire logic            SYS_RST,
    // APB slave
    input  wire logic            PSEL,
    input  wire logic            PENABLE,
    input  wire logic            PWRITE,
    input  wire logic [11:0]     PADDR,
    input  wire logic [31:0]     PWDATA,
    output logic                 PREADY,
    output logic [31:0]          PRDATA,
    output logic                 PSLVERR,
    // Pin
    input  wire logic            NMI_PIN_N,
    // Core side
    input  wire logic            MASKABLE_REQ,
    input  wire logic            RETURN_FROM_EXCEPTION,
    input  wire iedu_pkg::iedu_addr_t PROGRAM_COUNTER_IN,
    input  wire iedu_pkg::iedu_word_t PSW_IN,
    input  wire logic [4:0]      VECTOR_REGISTER_VALUE,
    // Dispatch table read
    output iedu_pkg::iedu_addr_t TABLE_ADDR,
    output logic                 TABLE_RD,
    input  wire iedu_pkg::iedu_word_t TABLE_DATA,
    // Results to core
    output iedu_pkg::iedu_addr_t PROGRAM_COUNTER,
    output iedu_pkg::iedu_word_t PROCESSOR_STATUS_WORD,
    output logic                 PC_LOAD,
    output logic                 ENTRY_BUSY,
    output logic                 TRAP_TAKEN
);
    iedu_state_e state, next_state;
    iedu_addr_t  irq_stack_pointer, next_irq_stack_pointer;
    iedu_addr_t  dispatch_table_base, next_dispatch_table_base;
    iedu_addr_t  saved_pc, next_saved_pc;
    iedu_word_t  saved_psw, next_saved_psw;
    iedu_addr_t  pc_q, next_pc_q;
    iedu_word_t  psw_q, next_psw_q;
    iedu_addr_t  taddr, next_taddr;
    logic [4:0]  vec, next_vec;
    logic        pc_load, next_pc_load;
    logic        trd, next_trd;
    logic        trap, next_trap;
    logic        pin_ctrl_en, next_pin_ctrl_en;
    logic        nmi_sticky_lock, next_nmi_sticky_lock;
    logic        ext_flag, next_ext_flag;
    logic        pend, next_pend;
    logic        sync1, sync2, pin_prev;
    logic        next_sync1, next_sync2, next_pin_prev;
    logic [31:0] rdata, next_rdata;
    logic        wr, rd, rd_setup, edge_fall, armed, pin_event;

    // [RULE14] Two-stage synchroniser; only the second stage feeds logic
    always_comb begin
        next_sync1    = NMI_PIN_N;
        next_sync2    = sync1;
        next_pin_prev = sync2;
    end

    // Stages reset to the pin's idle level, so release gives no false edge
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1    <= 1'b1;
            sync2    <= 1'b1;
            pin_prev <= 1'b1;
        end else begin
            sync1    <= next_sync1;
            sync2    <= next_sync2;
            pin_prev <= next_pin_prev;
        end
    end

    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    // [RULE13] Falling edge detect
    assign edge_fall = pin_prev && !sync2;
    // [RULE19] Lock overrides one-shot
    assign armed = nmi_sticky_lock || pin_ctrl_en;
    // Read data is fetched in the setup phase of a read
    assign rd_setup  = PSEL && !PENABLE && !PWRITE;
    assign pin_event = edge_fall && armed;

    always_comb begin
        next_state               = state;
        next_irq_stack_pointer   = irq_stack_pointer;
        next_dispatch_table_base = dispatch_table_base;
        next_saved_pc            = saved_pc;
        next_saved_psw           = saved_psw;
        next_pc_q                = pc_q;
        next_psw_q               = psw_q;
        next_taddr               = taddr;
        next_vec                 = vec;
        next_pc_load             = 1'b0;
        next_trd                 = 1'b0;
        next_trap                = 1'b0;
        next_pin_ctrl_en         = pin_ctrl_en;
        next_nmi_sticky_lock     = nmi_sticky_lock;
        next_ext_flag            = ext_flag;
        next_pend                = pend;
        // Register writes
        if (wr) begin
            if (PADDR == `IEDU_OFS_STACK_PTR) begin
                next_irq_stack_pointer = PWDATA[20:0];
            end else if (PADDR == `IEDU_OFS_BASE) begin
                // [RULE7] Fixed zero bits
                next_dispatch_table_base = {5'h00, PWDATA[15:1], 1'b0};
            end else if (PADDR == `IEDU_OFS_PIN_CTRL) begin
                next_pin_ctrl_en = PWDATA[`IEDU_FLD_EN];
                // [RULE18] Lock only sets
                if (PWDATA[`IEDU_FLD_LOCK]) begin
                    next_nmi_sticky_lock = 1'b1;
                end
            end
        end
        // Status clears on read, only the bit that the read reported
        if (rd && (PADDR == `IEDU_OFS_NMI_STAT)) begin
            next_ext_flag = ext_flag && !rdata[`IEDU_FLD_EXT];
        end
        // [RULE21] Ordered entry sequence
        case (state)
            IEDU_IDLE: begin
                if (RETURN_FROM_EXCEPTION) begin
                    // [RULE10] Pop context and raise pointer
                    next_pc_q    = saved_pc;
                    next_psw_q   = saved_psw;
                    next_pc_load = 1'b1;
                    // [RULE11] Stack shrinks upward
                    next_irq_stack_pointer = irq_stack_pointer + `IEDU_STACK_STEP;
                end else if (pend || MASKABLE_REQ) begin
                    next_state = IEDU_ADJUST;
                end
            end
            IEDU_ADJUST: begin
                // [RULE1] Lower pointer by four
                next_irq_stack_pointer = irq_stack_pointer - `IEDU_STACK_STEP;
                next_state = IEDU_SAVE;
            end
            IEDU_SAVE: begin
                // [RULE2] Save context
                next_saved_pc  = PROGRAM_COUNTER_IN;
                next_saved_psw = PSW_IN;
                next_state     = IEDU_CLEAR;
            end
            IEDU_CLEAR: begin
                // [RULE3] Clear I, P and T
                next_psw_q = PSW_IN;
                next_psw_q[`IEDU_PSW_I] = 1'b0;
                next_psw_q[`IEDU_PSW_P] = 1'b0;
                next_psw_q[`IEDU_PSW_T] = 1'b0;
                next_state = IEDU_VECTOR;
            end
            IEDU_VECTOR: begin
                // [RULE8] Pin trap vector one, else maskable
                if (pend) begin
                    next_vec  = `IEDU_NMI_VECTOR;
                    next_pend = 1'b0;
                    next_trap = 1'b1;
                end else begin
                    // [RULE4] [RULE20] Maskable vector read
                    next_vec = VECTOR_REGISTER_VALUE | `IEDU_MASKABLE_BASE;
                end
                next_state = IEDU_DISPATCH;
            end
            IEDU_DISPATCH: begin
                // [RULE5] Base plus twice the vector
                next_taddr = dispatch_table_base + {15'h0000, vec, 1'b0};
                next_trd   = 1'b1;
                if (trd) begin
                    // [RULE6] Pad entry with zeros
                    next_pc_q    = {4'h0, TABLE_DATA, 1'b0};
                    next_pc_load = 1'b1;
                    next_trd     = 1'b0;
                    next_state   = IEDU_IDLE;
                end
            end
            default: next_state = IEDU_IDLE;
        endcase
        // [RULE13] Trap request on edge when armed
        // After the sequencer, so a new edge beats the pend clear in VECTOR
        if (pin_event) begin
            next_pend     = 1'b1;
            next_ext_flag = 1'b1;
            // [RULE16] One-shot self clears
            if (!nmi_sticky_lock) begin
                next_pin_ctrl_en = 1'b0;
            end
        end
    end

    // Read data is captured in the setup phase so it stands through the access phase
    // Only the status read has a side effect, taken later at the access edge
    always_comb begin
        next_rdata = `IEDU_RST_ZERO;
        if (rd_setup) begin
            if (PADDR == `IEDU_OFS_STACK_PTR) begin
                next_rdata = {11'h000, irq_stack_pointer};
            end else if (PADDR == `IEDU_OFS_BASE) begin
                next_rdata = {11'h000, dispatch_table_base};
            end else if (PADDR == `IEDU_OFS_PIN_CTRL) begin
                next_rdata[`IEDU_FLD_EN]   = pin_ctrl_en;
                next_rdata[`IEDU_FLD_PIN]  = sync2;
                next_rdata[`IEDU_FLD_LOCK] = nmi_sticky_lock;
            end else if (PADDR == `IEDU_OFS_NMI_STAT) begin
                next_rdata[`IEDU_FLD_EXT] = ext_flag;
            end else if (PADDR == `IEDU_OFS_CONTEXT) begin
                next_rdata = {11'h000, saved_pc};
            end else if (PADDR == `IEDU_OFS_STACKED) begin
                next_rdata = {16'h0000, saved_psw};
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata <= `IEDU_RST_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    // [RULE15] Reset clears enables
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state               <= IEDU_IDLE;
            irq_stack_pointer   <= 21'h000000;
            dispatch_table_base <= 21'h000000;
            saved_pc            <= 21'h000000;
            saved_psw           <= 16'h0000;
            pc_q                <= 21'h000000;
            psw_q               <= 16'h0000;
            taddr               <= 21'h000000;
            vec                 <= 5'h00;
            pc_load             <= 1'b0;
            trd                 <= 1'b0;
            trap                <= 1'b0;
            pin_ctrl_en         <= 1'b0;
            nmi_sticky_lock     <= 1'b0;
            ext_flag            <= 1'b0;
            pend                <= 1'b0;
        end else begin
            state               <= next_state;
            irq_stack_pointer   <= next_irq_stack_pointer;
            dispatch_table_base <= next_dispatch_table_base;
            saved_pc            <= next_saved_pc;
            saved_psw           <= next_saved_psw;
            pc_q                <= next_pc_q;
            psw_q               <= next_psw_q;
            taddr               <= next_taddr;
            vec                 <= next_vec;
            pc_load             <= next_pc_load;
            trd                 <= next_trd;
            trap                <= next_trap;
            pin_ctrl_en         <= next_pin_ctrl_en;
            nmi_sticky_lock     <= next_nmi_sticky_lock;
            ext_flag            <= next_ext_flag;
            pend                <= next_pend;
        end
    end

    // Zero-wait APB; read data is registered so a read returns the setup-phase value
    assign PREADY                = 1'b1;
    assign PSLVERR               = 1'b0;
    assign PRDATA                = rdata;
    // Table address and strobe come straight from flip-flops
    assign TABLE_ADDR            = taddr;
    assign TABLE_RD              = trd;
    assign PROGRAM_COUNTER       = pc_q;
    assign PROCESSOR_STATUS_WORD = psw_q;
    assign PC_LOAD               = pc_load;
    assign ENTRY_BUSY            = (state != IEDU_IDLE);
    assign TRAP_TAKEN            = trap;
endmodule : iedu_unit

// file: tb/iedu_icu_model.sv
// Vector source and dispatch table memory beside the entry unit
`timescale 1ns/100ps
module iedu_icu_model
    import iedu_pkg::*;
(
    // Clock
    input  wire logic                 REF_CLK,
    // Table read
    input  wire iedu_pkg::iedu_addr_t TABLE_ADDR,
    input  wire logic                 TABLE_RD,
    output iedu_pkg::iedu_word_t      TABLE_DATA,
    // Vector
    output logic [4:0]                VECTOR_REGISTER_VALUE
);
    iedu_word_t junk;
    initial junk = 16'h3C3C;
    // Encoded vector of maskable source five
    assign VECTOR_REGISTER_VALUE = 5'h15;
    assign TABLE_DATA = TABLE_RD ? ((TABLE_ADDR[16:1] ^ 16'h0A5A) & 16'h5FFF) : junk;
    // Idle bus toggles so stale data never looks valid
    always @(posedge REF_CLK) begin
        junk <= ~TABLE_DATA;
    end
endmodule : iedu_icu_model

// file: tb/iedu_unit_asserts.sv
// Port checks for the exception entry unit
`timescale 1ns/100ps
module iedu_unit_asserts
    import iedu_pkg::*;
(
    // Clock and reset
    input wire logic                 REF_CLK,
    input wire logic                 SYS_RST,
    // Watched ports
    input wire logic                 PREADY,
    input wire logic                 PSLVERR,
    input wire logic                 NMI_PIN_N,
    input wire logic                 TABLE_RD,
    input wire iedu_pkg::iedu_addr_t PROGRAM_COUNTER,
    input wire iedu_pkg::iedu_word_t PROCESSOR_STATUS_WORD,
    input wire logic                 PC_LOAD,
    input wire logic                 ENTRY_BUSY,
    input wire logic                 TRAP_TAKEN
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    ready_high_a: assert property (PREADY) else $error("pready low");
    no_error_a: assert property (!PSLVERR) else $error("pslverr high");
    step_order_a: assert property ($rose(ENTRY_BUSY) |-> (!TABLE_RD) [*3])
        else $error("table read too early");
    entry_pad_a: assert property ($rose(TABLE_RD) |-> ##[1:3] PC_LOAD &&
        !PROGRAM_COUNTER[0] && PROGRAM_COUNTER[20:17] == 4'h0) else $error("entry pad wrong");
    psw_clear_a: assert property ($rose(TABLE_RD) |-> ##[1:3] PC_LOAD &&
        PROCESSOR_STATUS_WORD[11:10] == 2'b00 && !PROCESSOR_STATUS_WORD[1])
        else $error("status bits not cleared");
    trap_busy_a: assert property (TRAP_TAKEN |-> ENTRY_BUSY)
        else $error("trap outside entry");
    pin_sync_a: assert property ($fell(NMI_PIN_N) |-> (!TRAP_TAKEN) [*2])
        else $error("pin not synchronised");
    load_pulse_a: assert property (PC_LOAD |=> !PC_LOAD) else $error("load not a pulse");
    trap_pulse_a: assert property (TRAP_TAKEN |=> !TRAP_TAKEN)
        else $error("trap not a pulse");
    cover property ($rose(TABLE_RD));
    cover property (TRAP_TAKEN);
    cover property (PC_LOAD && !ENTRY_BUSY);
endmodule : iedu_unit_asserts

// file: tb/iedu_unit_tb.sv
// Self-checking bench for the exception entry unit
`timescale 1ns/100ps
`include "iedu_regs.svh"
module iedu_unit_tb;
    import iedu_pkg::*;
    logic        clk, rst, psel, pen, pwr, pready, pslverr, nmi_n;
    logic        mreq, return_from_exception, trd, ld, busy, trap;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [4:0]  vec;
    iedu_addr_t  pc_in, taddr, pc;
    iedu_word_t  psw_in, tdata, psw;
    int          n_fail, n_checks, cyc, traps, n0;
    iedu_unit uut (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
        .NMI_PIN_N(nmi_n), .MASKABLE_REQ(mreq), .RETURN_FROM_EXCEPTION(return_from_exception),
        .PROGRAM_COUNTER_IN(pc_in), .PSW_IN(psw_in), .VECTOR_REGISTER_VALUE(vec),
        .TABLE_ADDR(taddr), .TABLE_RD(trd), .TABLE_DATA(tdata), .PROGRAM_COUNTER(pc),
        .PROCESSOR_STATUS_WORD(psw), .PC_LOAD(ld), .ENTRY_BUSY(busy), .TRAP_TAKEN(trap));
    iedu_icu_model icu (.REF_CLK(clk), .TABLE_ADDR(taddr), .TABLE_RD(trd), .TABLE_DATA(tdata),
        .VECTOR_REGISTER_VALUE(vec));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        traps <= traps + (trap === 1'b1);
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    function automatic logic [31:0] rtn(input logic [20:0] a);
        return {15'h0000, (a[16:1] ^ 16'h0A5A) & 16'h5FFF, 1'b0};
    endfunction : rtn
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Request holds until pready is seen high; read data is taken at that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdv = prdata;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task wait_load();
        int k;
        k = 0;
        #1;
        while (ld !== 1'b1 && k < 50) begin
            @(posedge clk); #1; k++;
        end
        chk("pc_load", 32'h1, {31'h0, ld});
    endtask : wait_load
    task pulse_pin();
        @(posedge clk);
        nmi_n <= 1'b0;
        repeat (4) @(posedge clk);
        nmi_n <= 1'b1;
        repeat (30) @(posedge clk);
    endtask : pulse_pin
    task t_reset();
        apb(1'b0, `IEDU_OFS_PIN_CTRL, 32'h0);
        chk("pin reset", 32'h2, rdv);
        apb(1'b0, `IEDU_OFS_NMI_STAT, 32'h0);
        chk("ext reset", 32'h0, rdv);
    endtask : t_reset
    task t_entry();
        apb(1'b1, `IEDU_OFS_STACK_PTR, 32'h1000);
        apb(1'b1, `IEDU_OFS_BASE, 32'h001F0201);
        apb(1'b0, `IEDU_OFS_BASE, 32'h0);
        chk("base", 32'h200, rdv);
        @(posedge clk);
        pc_in  <= 21'h012345;
        psw_in <= 16'hFFFF;
        mreq   <= 1'b1;
        while (busy !== 1'b1 && cyc < 19000) @(posedge clk);
        mreq <= 1'b0;
        wait_load();
        // Vector 21 is maskable source five
        chk("entry pc", rtn(21'h200 + 21'h2A), {11'h0, pc});
        chk("entry psw", 32'hF3FD, {16'h0, psw});
        apb(1'b0, `IEDU_OFS_STACK_PTR, 32'h0);
        chk("sp push", 32'h0FFC, rdv);
        apb(1'b0, `IEDU_OFS_CONTEXT, 32'h0);
        chk("saved pc", 32'h012345, rdv);
        apb(1'b0, `IEDU_OFS_STACKED, 32'h0);
        chk("saved psw", 32'hFFFF, rdv);
        @(posedge clk);
        pc_in  <= 21'h0;
        psw_in <= 16'h0;
        return_from_exception   <= 1'b1;
        @(posedge clk);
        return_from_exception <= 1'b0;
        wait_load();
        chk("ret pc", 32'h012345, {11'h0, pc});
        chk("ret psw", 32'hFFFF, {16'h0, psw});
        apb(1'b0, `IEDU_OFS_STACK_PTR, 32'h0);
        chk("sp pop", 32'h1000, rdv);
    endtask : t_entry
    task t_nmi();
        n0 = traps;
        pulse_pin();
        chk("trap off", n0, traps);
        apb(1'b1, `IEDU_OFS_PIN_CTRL, 32'h1);
        pulse_pin();
        chk("trap on", n0 + 1, traps);
        chk("trap pc", rtn(21'h200 + 21'h2), {11'h0, pc});
        apb(1'b0, `IEDU_OFS_NMI_STAT, 32'h0);
        chk("ext set", 32'h40, rdv);
        apb(1'b0, `IEDU_OFS_NMI_STAT, 32'h0);
        chk("ext cleared", 32'h0, rdv);
        apb(1'b0, `IEDU_OFS_PIN_CTRL, 32'h0);
        chk("oneshot", 32'h2, rdv);
        pulse_pin();
        chk("trap spent", n0 + 1, traps);
        apb(1'b1, `IEDU_OFS_PIN_CTRL, 32'h1);
        pulse_pin();
        chk("trap rearmed", n0 + 2, traps);
    endtask : t_nmi
    task t_lock();
        n0 = traps;
        apb(1'b1, `IEDU_OFS_PIN_CTRL, 32'h4);
        apb(1'b1, `IEDU_OFS_PIN_CTRL, 32'h0);
        apb(1'b0, `IEDU_OFS_PIN_CTRL, 32'h0);
        chk("lock", 32'h6, rdv);
        // Second edge lands while the first trap is in service
        @(posedge clk);
        nmi_n <= 1'b0;
        repeat (4) @(posedge clk);
        nmi_n <= 1'b1;
        pulse_pin();
        chk("nested", n0 + 2, traps);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `IEDU_OFS_PIN_CTRL, 32'h0);
        chk("lock reset", 32'h2, rdv);
    endtask : t_lock
    task conclude();
        $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    initial begin
        rst      = 1'b1;
        psel     = 1'b0;
        pen      = 1'b0;
        pwr      = 1'b0;
        paddr    = 12'h0;
        pwdata   = 32'h0;
        nmi_n    = 1'b1;
        mreq     = 1'b0;
        return_from_exception     = 1'b0;
        pc_in    = 21'h0;
        psw_in   = 16'h0;
        n_fail   = 0;
        n_checks = 0;
        cyc      = 0;
        traps    = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_entry();
        t_nmi();
        t_lock();
        conclude();
    end
endmodule : iedu_unit_tb
bind iedu_unit iedu_unit_asserts u_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .NMI_PIN_N(NMI_PIN_N), .TABLE_RD(TABLE_RD),
    .PROGRAM_COUNTER(PROGRAM_COUNTER), .PROCESSOR_STATUS_WORD(PROCESSOR_STATUS_WORD),
    .PC_LOAD(PC_LOAD), .ENTRY_BUSY(ENTRY_BUSY), .TRAP_TAKEN(TRAP_TAKEN));
